/* hw/psbi_regs.vh */
`ifndef PSBI_REGS_VH
`define PSBI_REGS_VH

// ****************************************************************
// mode register field positions (taken from address bits)
// ****************************************************************
`define PSBI_BL_LSB 5
`define PSBI_BL_MSB 7
`define PSBI_BT_BIT 8
`define PSBI_LAT_LSB 9
`define PSBI_LAT_MSB 11
`define PSBI_RSV_BIT 12
`define PSBI_WP_BIT 13
`define PSBI_OPM_LSB 14
`define PSBI_OPM_MSB 15
`define PSBI_DS_LSB 16
`define PSBI_DS_MSB 17
`define PSBI_MR_W 18

// ****************************************************************
// field codes and defaults
// ****************************************************************
`define PSBI_BL_4 3'h2
`define PSBI_BL_8 3'h3
`define PSBI_BL_16 3'h4
`define PSBI_BL_DEF 3'h2
`define PSBI_BT_DEF 1'h0
`define PSBI_LAT_3 3'h0
`define PSBI_LAT_4 3'h1
`define PSBI_LAT_5 3'h2
`define PSBI_LAT_DEF 3'h0
`define PSBI_OPM_ASYNC 2'h0
`define PSBI_OPM_SRD 2'h1
`define PSBI_OPM_SYNC 2'h2
`define PSBI_DS_FULL 2'h0
`define PSBI_DS_HALF 2'h1
`define PSBI_DS_QTR 2'h2
`define PSBI_MR_RST 18'h00040

// ****************************************************************
// software load sequence addresses
// ****************************************************************
`define PSBI_SEQ_ADDR_A 21'h1FFFFF
`define PSBI_SEQ_ADDR_B 21'h1FFEFF

// ****************************************************************
// timing
// ****************************************************************
`define PSBI_CLK_PERIOD_NS 25
`define PSBI_PWRUP_NS 200000
`define PSBI_PWRUP_CYC \
  ((`PSBI_PWRUP_NS + `PSBI_CLK_PERIOD_NS - 1) / `PSBI_CLK_PERIOD_NS)
`define PSBI_RD_FIRST_OFS 5'h04
`define PSBI_WR_FIRST_OFS 5'h02

`endif

/* hw/psbi_mode_decode.v */
`timescale 1ns/1ps
`default_nettype none
`include "psbi_regs.vh"

module psbi_mode_decode (
  input wire [20:0] raw,
  output reg [17:0] mode
);

  reg [2:0] bl;
  reg [2:0] lat;
  reg [1:0] opm;
  reg [1:0] ds;

  // ****************************************************************
  // reserved codes fall back to each field's default
  // ****************************************************************
  always @* begin
    bl = raw[`PSBI_BL_MSB:`PSBI_BL_LSB];
    lat = raw[`PSBI_LAT_MSB:`PSBI_LAT_LSB];
    opm = raw[`PSBI_OPM_MSB:`PSBI_OPM_LSB];
    ds = raw[`PSBI_DS_MSB:`PSBI_DS_LSB];
    if (bl != `PSBI_BL_4 && bl != `PSBI_BL_8 && bl != `PSBI_BL_16) begin
      bl = `PSBI_BL_DEF;
    end
    if (lat != `PSBI_LAT_3 && lat != `PSBI_LAT_4 && lat != `PSBI_LAT_5) begin
      lat = `PSBI_LAT_DEF;
    end
    if (opm == 2'h3) begin
      opm = `PSBI_OPM_ASYNC;
    end
    if (ds == 2'h3) begin
      ds = `PSBI_DS_FULL;
    end
    mode = 18'h00000;
    mode[`PSBI_BL_MSB:`PSBI_BL_LSB] = bl;
    mode[`PSBI_BT_BIT] = `PSBI_BT_DEF;
    mode[`PSBI_LAT_MSB:`PSBI_LAT_LSB] = lat;
    mode[`PSBI_WP_BIT] = raw[`PSBI_WP_BIT];
    mode[`PSBI_OPM_MSB:`PSBI_OPM_LSB] = opm;
    mode[`PSBI_DS_MSB:`PSBI_DS_LSB] = ds;
    // bits 18 and up of raw are never looked at
  end

endmodule
`default_nettype wire

/* hw/psbi_bus_if.v */
`timescale 1ns/1ps
`default_nettype none
`include "psbi_regs.vh"

// Summary of operation
// - device starts in async page read and async write mode
// - async mode: chip select gates, oe reads, we writes, byte lanes
// - async mode ignores the burst clock; address-valid strobe only steers mode register loads
// - wait pin is high impedance in async mode
// - mode 0/1: sync read command on clock edge, writes async
// - mode 1/0: read and write commands on clock edge, lanes masked
// - mode register loads from address with all strobes low, oe high
// - reserved field codes fall back to the field default
// - burst length, latency taken from address bits 5 to 11, type fixed at default
// - wait polarity bit 13, operating mode bits 14 to 15
// - drive strength from address bits 16 to 17
// - address bits 18 and up do not affect the mode register
// - five async reads with set addresses load the mode register
// - burst starts at first clock edge of a low strobe period
// - first data after latency plus one read, minus one write
module psbi_bus_if #(
  parameter PWRUP_CYC = `PSBI_PWRUP_CYC
) (
  input wire core_clk,
  input wire rstn,
  input wire burst_clk,
  input wire cs_n,
  input wire oe_n,
  input wire we_n,
  input wire address_valid_strobe_n,
  input wire upper_byte_enable_n,
  input wire lower_byte_enable_n,
  input wire [20:0] addr,
  input wire [15:0] dq_in,
  output reg [15:0] dq_out_r,
  output reg [1:0] dq_oe_r,
  output reg wait_out_r,
  output reg wait_oe_r,
  output reg [1:0] drive_strength_r
);

  localparam ST_IDLE = 3'b001;
  localparam ST_LAT = 3'b010;
  localparam ST_DATA = 3'b100;

  reg [15:0] mem [0:2097151];

  reg [17:0] mode_r;
  reg [17:0] pend_r;
  reg pend_vld_r;
  reg [15:0] pwr_cnt_r;
  reg pwr_ok_r;
  reg clk_q_r;
  reg cs_q_r;
  reg adv_used_r;
  reg hw_seen_r;
  reg in_rd_r;
  reg [20:0] rd_addr_r;
  reg [2:0] seq_cnt_r;
  reg [2:0] state_r;
  reg [4:0] cnt_r;
  reg [4:0] beats_r;
  reg bwr_r;
  reg [20:0] baddr_r;

  wire [17:0] ld_mode;
  wire [1:0] opm = mode_r[`PSBI_OPM_MSB:`PSBI_OPM_LSB];
  wire [2:0] lat = mode_r[`PSBI_LAT_MSB:`PSBI_LAT_LSB];
  wire [2:0] blc = mode_r[`PSBI_BL_MSB:`PSBI_BL_LSB];
  wire async_md = (opm == `PSBI_OPM_ASYNC);
  wire sync_wr = (opm == `PSBI_OPM_SYNC);
  wire sel = ~cs_n & pwr_ok_r;
  wire clk_rise = burst_clk & ~clk_q_r;
  wire [1:0] lanes = {~upper_byte_enable_n, ~lower_byte_enable_n};
  wire [15:0] lane_mask = {{8{lanes[1]}}, {8{lanes[0]}}};
  wire hw_ld = sel & ~address_valid_strobe_n & ~we_n & oe_n &
    (lanes == 2'h3) & ~hw_seen_r;
  wire cs_rise = cs_n & ~cs_q_r;
  wire sw_ld = cs_rise & in_rd_r & (seq_cnt_r == 3'h4);
  wire [4:0] first = bwr_r ? ({2'h0, lat} + `PSBI_WR_FIRST_OFS) :
    ({2'h0, lat} + `PSBI_RD_FIRST_OFS);
  wire [4:0] bl_len = (blc == `PSBI_BL_16) ? 5'h10 :
    (blc == `PSBI_BL_8) ? 5'h08 : 5'h04;
  wire [20:0] wrap_m = {16'h0000, bl_len - 5'h01};
  wire [20:0] baddr_nxt = (baddr_r & ~wrap_m) |
    ((baddr_r + 21'h000001) & wrap_m);
  wire [4:0] cnt_nxt = cnt_r + 5'h01;
  wire burst_on = (state_r != ST_IDLE);
  wire cmd = sel & ~async_md & clk_rise & ~address_valid_strobe_n &
    ~adv_used_r & ~burst_on & (we_n | sync_wr) & ~hw_ld;
  wire beat = sel & burst_on & clk_rise & (cnt_nxt >= first);
  wire async_wr = sel & ~we_n & oe_n & ~burst_on & ~hw_ld & ~sync_wr;
  wire mem_we = (async_wr | (beat & bwr_r)) & (lanes != 2'h0);
  wire [20:0] mem_a = burst_on ? baddr_r : addr;
  wire [15:0] old_w = mem[mem_a];
  wire [15:0] new_w = (dq_in & lane_mask) | (old_w & ~lane_mask);

  psbi_mode_decode u_dec (
    .raw(hw_ld ? addr : rd_addr_r),
    .mode(ld_mode)
  );

  // ****************************************************************
  // storage array, byte lanes merged into the stored word
  // ****************************************************************
  always @(posedge core_clk) begin
    if (mem_we) begin
      mem[mem_a] <= new_w;
    end
  end

  // ****************************************************************
  // power-up hold, mode register, software load sequence
  // ****************************************************************
  always @(posedge core_clk) begin
    if (!rstn) begin
      mode_r <= `PSBI_MR_RST;
      pend_r <= `PSBI_MR_RST;
      pend_vld_r <= 1'b0;
      pwr_cnt_r <= 16'h0000;
      pwr_ok_r <= 1'b0;
      cs_q_r <= 1'b1;
      hw_seen_r <= 1'b0;
      in_rd_r <= 1'b0;
      rd_addr_r <= 21'h000000;
      seq_cnt_r <= 3'h0;
      drive_strength_r <= `PSBI_DS_FULL;
    end else begin
      cs_q_r <= cs_n;
      // accesses before the hold has elapsed would hit an unsettled array
      if (!pwr_ok_r) begin
        if (!cs_n) begin
          pwr_cnt_r <= 16'h0000;
        end else if (pwr_cnt_r >= PWRUP_CYC[15:0] - 16'h0001) begin
          pwr_ok_r <= 1'b1;
        end else begin
          pwr_cnt_r <= pwr_cnt_r + 16'h0001;
        end
      end
      if (cs_n) begin
        hw_seen_r <= 1'b0;
      end else if (hw_ld) begin
        hw_seen_r <= 1'b1;
      end
      if (sel & ~oe_n & we_n) begin
        in_rd_r <= 1'b1;
        rd_addr_r <= addr;
      end else if (cs_rise) begin
        in_rd_r <= 1'b0;
      end
      if (cs_rise & in_rd_r) begin
        if (seq_cnt_r == 3'h4) begin
          seq_cnt_r <= 3'h0;
        end else if (seq_cnt_r == 3'h3) begin
          seq_cnt_r <= (rd_addr_r == `PSBI_SEQ_ADDR_B) ? 3'h4 :
            (rd_addr_r == `PSBI_SEQ_ADDR_A) ? 3'h3 : 3'h0;
        end else begin
          seq_cnt_r <= (rd_addr_r == `PSBI_SEQ_ADDR_A) ?
            seq_cnt_r + 3'h1 : 3'h0;
        end
      end else if (cs_rise & ~in_rd_r) begin
        seq_cnt_r <= 3'h0;
      end
      // a loaded value waits for an idle bus so no access sees it change
      if (pend_vld_r & cs_n & ~burst_on) begin
        mode_r <= pend_r;
        drive_strength_r <= pend_r[`PSBI_DS_MSB:`PSBI_DS_LSB];
        pend_vld_r <= 1'b0;
      end
      if (hw_ld | sw_ld) begin
        pend_r <= ld_mode;
        pend_vld_r <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // burst engine
  // ****************************************************************
  always @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      clk_q_r <= 1'b0;
      adv_used_r <= 1'b0;
      cnt_r <= 5'h00;
      beats_r <= 5'h00;
      bwr_r <= 1'b0;
      baddr_r <= 21'h000000;
    end else begin
      clk_q_r <= burst_clk;
      if (address_valid_strobe_n | cs_n) begin
        adv_used_r <= 1'b0;
      end else if (cmd) begin
        adv_used_r <= 1'b1;
      end
      case (state_r)
        ST_IDLE: begin
          if (cmd) begin
            state_r <= ST_LAT;
            cnt_r <= 5'h00;
            beats_r <= 5'h00;
            bwr_r <= ~we_n;
            baddr_r <= addr;
          end
        end
        ST_LAT, ST_DATA: begin
          if (cs_n) begin
            state_r <= ST_IDLE;
          end else if (clk_rise) begin
            cnt_r <= cnt_nxt;
            if (cnt_nxt >= first) begin
              state_r <= ST_DATA;
              baddr_r <= baddr_nxt;
              beats_r <= beats_r + 5'h01;
              if (beats_r == bl_len - 5'h01) begin
                state_r <= ST_IDLE;
              end
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // data and wait pins
  // ****************************************************************
  always @(posedge core_clk) begin
    if (!rstn) begin
      dq_out_r <= 16'h0000;
      dq_oe_r <= 2'h0;
      wait_out_r <= 1'b0;
      wait_oe_r <= 1'b0;
    end else begin
      if (burst_on) begin
        if (beat & ~bwr_r) begin
          dq_out_r <= old_w;
        end
      end else begin
        dq_out_r <= old_w;
      end
      if (sel & async_md & ~oe_n & we_n) begin
        dq_oe_r <= lanes;
      end else if (sel & (state_r == ST_DATA) & ~bwr_r & ~oe_n) begin
        dq_oe_r <= lanes;
      end else if (sel & beat & ~bwr_r & ~oe_n) begin
        dq_oe_r <= lanes;
      end else begin
        dq_oe_r <= 2'h0;
      end
      wait_oe_r <= sel & ~async_md;
      wait_out_r <= mode_r[`PSBI_WP_BIT] ? (state_r == ST_LAT) :
        ~(state_r == ST_LAT);
    end
  end

endmodule
`default_nettype wire

/* hw/psbi_dummy_unused_marker.v */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* test/psbi_bus_if_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module psbi_bus_if_chk #(
  parameter PWRUP_CYC = 20
) (
  input wire core_clk,
  input wire rstn,
  input wire cs_n,
  input wire oe_n,
  input wire upper_byte_enable_n,
  input wire lower_byte_enable_n,
  input wire [1:0] dq_oe_r,
  input wire wait_oe_r,
  input wire [1:0] drive_strength_r
);
  // ****************************************
  // power-up tracker, one short of the design
  // ****************************************
  reg [15:0] up_cnt_r;
  always @(posedge core_clk) begin
    if (!rstn) begin
      up_cnt_r <= 16'h0000;
    end else if (up_cnt_r < PWRUP_CYC) begin
      up_cnt_r <= cs_n ? up_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_pwrup_quiet: assert property (
    (up_cnt_r < PWRUP_CYC - 1) |=> dq_oe_r == 2'h0)
    else $error("lanes driven before power-up done");
  a_rst_clear: assert property ($rose(rstn) |->
    dq_oe_r == 2'h0 && !wait_oe_r && drive_strength_r == 2'h0)
    else $error("outputs not cleared by reset");
  a_desel_hiz: assert property (
    cs_n |=> dq_oe_r == 2'h0 && !wait_oe_r)
    else $error("drive while deselected");
  a_oe_gate: assert property (oe_n |=> dq_oe_r == 2'h0)
    else $error("lanes driven with output enable high");
  a_upper_lane: assert property (
    upper_byte_enable_n |=> !dq_oe_r[1])
    else $error("upper lane driven while disabled");
  a_lower_lane: assert property (
    lower_byte_enable_n |=> !dq_oe_r[0])
    else $error("lower lane driven while disabled");
  a_ds_legal: assert property (drive_strength_r != 2'h3)
    else $error("reserved drive strength in use");
  a_ds_apply: assert property (
    $changed(drive_strength_r) |-> $past(cs_n, 1))
    else $error("drive strength changed mid access");
endmodule
bind psbi_bus_if psbi_bus_if_chk #(.PWRUP_CYC(PWRUP_CYC)) u_chk (
  .core_clk, .rstn, .cs_n, .oe_n, .upper_byte_enable_n,
  .lower_byte_enable_n, .dq_oe_r, .wait_oe_r, .drive_strength_r);
`default_nettype wire

/* test/psbi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module psbi_host_model (
  input wire logic core_clk,
  output logic burst_clk,
  output logic cs_n,
  output logic oe_n,
  output logic we_n,
  output logic address_valid_strobe_n,
  output logic upper_byte_enable_n,
  output logic lower_byte_enable_n,
  output logic [20:0] addr,
  output logic [15:0] dq_in
);
  // the only burst write is in the final synchronous section,
  // and no async write follows it
  initial begin
    {cs_n, oe_n, we_n, address_valid_strobe_n} = 4'hF;
    {upper_byte_enable_n, lower_byte_enable_n} = 2'h3;
    {burst_clk, addr, dq_in} = 38'h0;
  end
  // s = {cs, oe, we, adv, upper, lower}, all active low
  task drv(input logic [5:0] s, input logic [20:0] a,
    input logic [15:0] d);
    @(posedge core_clk);
    {cs_n, oe_n, we_n, address_valid_strobe_n} <= s[5:2];
    {upper_byte_enable_n, lower_byte_enable_n} <= s[1:0];
    addr <= a;
    dq_in <= s[3] ? ~dq_in : d; // released bus never holds its value
  endtask
  // burst clock stands still outside bursts and the async wait check; a quarter of core rate
  task bclk(input int n);
    repeat (n) begin
      @(posedge core_clk);
      burst_clk <= 1'b1;
      repeat (2) @(posedge core_clk);
      burst_clk <= 1'b0;
      @(posedge core_clk);
    end
    #1;
  endtask
endmodule
`default_nettype wire

/* test/tb_psbi_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "psbi_regs.vh"
module tb_psbi_bus_if;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic burst_clk, cs_n, oe_n, we_n, address_valid_strobe_n;
  logic upper_byte_enable_n, lower_byte_enable_n;
  logic [20:0] addr;
  logic [15:0] dq_in, dq_out_r;
  logic [1:0] dq_oe_r, drive_strength_r;
  logic wait_out_r, wait_oe_r;
  int n_fail = 0;
  int n_checks = 0;
  logic [20:0] ds_a[4] = '{21'h020000, 21'h030000, 21'h1D0000, 0};
  logic [15:0] ds_e[4] = '{16'h2, 16'h0, 16'h1, 16'h0};
  logic [20:0] sw_a[5] = '{`PSBI_SEQ_ADDR_A, `PSBI_SEQ_ADDR_A,
    `PSBI_SEQ_ADDR_A, `PSBI_SEQ_ADDR_B, 21'h010000};
  always #12.5 core_clk = ~core_clk;
  psbi_host_model u_psbi_host_model (.core_clk, .burst_clk, .cs_n,
    .oe_n, .we_n, .address_valid_strobe_n, .upper_byte_enable_n,
    .lower_byte_enable_n, .addr, .dq_in);
  psbi_bus_if #(.PWRUP_CYC(20)) u_psbi_bus_if (.core_clk, .rstn,
    .burst_clk, .cs_n, .oe_n, .we_n, .address_valid_strobe_n,
    .upper_byte_enable_n, .lower_byte_enable_n, .addr, .dq_in,
    .dq_out_r, .dq_oe_r, .wait_out_r, .wait_oe_r, .drive_strength_r);
  task chk(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task test_done;
    if (n_fail == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task drv(input logic [5:0] s, input logic [20:0] a);
    u_psbi_host_model.drv(s, a, 16'h0000);
  endtask
  task wr(input logic [5:0] s, input logic [20:0] a,
    input logic [15:0] d);
    u_psbi_host_model.drv(s, a, d);
    drv(6'h3F, a);
  endtask
  task rd(input logic [5:0] s, input logic [20:0] a);
    drv(s, a);
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task mload(input logic [20:0] a, input logic [15:0] exp);
    wr(6'h10, a, 16'h0000);
    repeat (2) @(posedge core_clk);
    #1 chk("drive_strength", drive_strength_r, exp);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge core_clk);
    rd(6'h0C, 21'h00000);
    chk("early_lanes", dq_oe_r, 16'h0);
    drv(6'h3F, 21'h0);
    repeat (25) @(posedge core_clk);
    wr(6'h14, 21'h12344, 16'h1234);
    wr(6'h14, 21'h12345, 16'hA5C3);
    wr(6'h15, 21'h12345, 16'h77EE);
    rd(6'h0C, 21'h12345);
    chk("word_rd", dq_out_r, 16'h77C3);
    chk("word_lanes", dq_oe_r, 16'h3);
    rd(6'h0E, 21'h12345);
    chk("lower_lanes", dq_oe_r, 16'h1);
    drv(6'h08, 21'h12345);
    u_psbi_host_model.bclk(4);
    chk("async_wait", {dq_out_r[7:0], wait_oe_r}, 16'h186);
    rd(6'h3F, 21'h0);
    chk("deselect", {dq_oe_r, wait_oe_r}, 16'h0);
    foreach (ds_a[i]) mload(ds_a[i], ds_e[i]);
    // chip select must rise after every read or the sequence never counts
    foreach (sw_a[i]) begin
      rd(6'h0C, sw_a[i]);
      drv(6'h3F, 21'h0);
    end
    drv(6'h3F, 21'h0);
    repeat (3) @(posedge core_clk);
    #1 chk("sw_load", drive_strength_r, 16'h1);
    mload(21'h024040, 16'h2);
    drv(6'h08, 21'h12344);
    u_psbi_host_model.bclk(2);
    chk("burst_wait", {wait_oe_r, wait_out_r}, 16'h2);
    drv(6'h0C, 21'h12344);
    u_psbi_host_model.bclk(3);
    chk("beat0", dq_out_r, 16'h1234);
    chk("beat0_wait", {dq_oe_r, wait_out_r}, 16'h7);
    u_psbi_host_model.bclk(1);
    chk("beat1", dq_out_r, 16'h77C3);
    rd(6'h3F, 21'h0);
    chk("burst_stop", {dq_oe_r, wait_oe_r}, 16'h0);
    // ****************************************
    // fully synchronous mode: burst write, burst read back
    // ****************************************
    wr(6'h14, 21'h00000, 16'h0000);
    mload(21'h018040, 16'h1);
    u_psbi_host_model.drv(6'h00, 21'h22220, 16'h0000);
    u_psbi_host_model.bclk(1);
    u_psbi_host_model.drv(6'h14, 21'h22220, 16'hBEEF);
    u_psbi_host_model.bclk(2);
    u_psbi_host_model.drv(6'h14, 21'h22220, 16'h5A5A);
    u_psbi_host_model.bclk(1);
    drv(6'h3F, 21'h0);
    drv(6'h08, 21'h22220);
    u_psbi_host_model.bclk(1);
    drv(6'h0C, 21'h22220);
    u_psbi_host_model.bclk(4);
    chk("wr_beat0", dq_out_r, 16'hBEEF);
    u_psbi_host_model.bclk(1);
    chk("wr_beat1", dq_out_r, 16'h5A5A);
    rd(6'h3F, 21'h0);
    chk("sync_stop", {dq_oe_r, wait_oe_r}, 16'h0);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
